// ---- design/charge_timer_pkg.sv ----
// Shared constants, register map and carrier types of the charge timer.
// Assumes a single 100 MHz oscillator clock and an AXI4-Lite register bus.
package charge_timer_pkg;

  localparam int CLK_MHZ      = 100;
  // Exponents of the timing chain, in prescaled ticks
  localparam int TOUT_EXP     = 26;
  localparam int HOLD_SHIFT   = 5;
  localparam int NTC_EXP      = 17;
  localparam int VPEAK_EXP    = 16;
  localparam int SENSE_EXP    = 10;
  // Peak detector: 14-bit store, full at a drop of 1/400 of the peak
  localparam int PEAK_W       = 14;
  localparam int PEAK_DEN     = 400;
  // Pulse-width output: cycle length and duty ceiling in percent
  localparam int PWM_CYC      = 100;
  localparam int DUTY_PCT     = 79;
  localparam int PCT          = 100;
  // Start-up and buzzer lengths in microseconds
  localparam int INIT_TIME_US = 100;
  localparam int BUZZ_TIME_US = 20;
  localparam int BUZZ_CYC     = BUZZ_TIME_US * CLK_MHZ;

  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_PEAK   = 4'h8;
  localparam logic [3:0] ADDR_TIMER  = 4'hc;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] DIV_MIN     = 4'h1;

  typedef struct packed {
    logic [13:0] slope_thr;
    logic [3:0]  filt_n;
    logic        restart;
    logic        slope_en;
    logic        peak_en;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{slope_thr: 14'h0040, filt_n: 4'h3,
                                   restart: 1'b0, slope_en: 1'b1,
                                   peak_en: 1'b1};

  typedef struct packed {
    logic [3:0] presc;
    logic [3:0] tout;
    logic [3:0] slope;
  } div_s;

  typedef enum logic [2:0] {
    st_init, st_fast, st_full, st_timeout, st_refresh
  } state_e;

endpackage : charge_timer_pkg

// ---- design/period_counter.sv ----
// Modulo counter that advances on an enable and flags its last count.
// Assumes limit is at least one and stable while counting.
`timescale 1ns/1ps
module period_counter #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         en,
  input  wire logic         clr,
  input  wire logic [W-1:0] limit,
  // Count
  output      logic [W-1:0] count_q,
  output      logic         last
);

  assign last = en && (count_q == limit - 1'b1);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      count_q <= '0;
    else if (clr || last)
      count_q <= '0;
    else if (en)
      count_q <= count_q + 1'b1;
  end

endmodule : period_counter

// ---- design/charge_timer_full_detect.sv ----
// Charger timing chain, peak and slope full detection, indication, PWM.
// Assumes pins pass through a synchroniser here; sample words come from a
// converter on clk and are valid whenever a sample strobe fires.
`timescale 1ns/1ps
module charge_timer_full_detect #(
  parameter int TOUT_EXP  = charge_timer_pkg::TOUT_EXP,
  parameter int NTC_EXP   = charge_timer_pkg::NTC_EXP,
  parameter int VPEAK_EXP = charge_timer_pkg::VPEAK_EXP,
  parameter int SENSE_EXP = charge_timer_pkg::SENSE_EXP,
  parameter int INIT_CYC  = charge_timer_pkg::INIT_TIME_US *
                            charge_timer_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins, asynchronous
  input  wire logic        standby_control_pin_low,
  input  wire logic        standby_control_pin_high,
  input  wire logic        low_supply_in,
  input  wire logic        temp_prot_in,
  input  wire logic        battery_insert_in,
  input  wire logic        discharge_request_pin,
  input  wire logic        pwm_stop_in,
  input  wire logic [3:0]  presc_div_in,
  input  wire logic [3:0]  tout_div_in,
  input  wire logic [3:0]  slope_div_in,
  // Converter samples, on clk
  input  wire logic [13:0] vbat_data,
  input  wire logic [13:0] ntc_data,
  // Charge control
  output      logic        charge_on_q,
  output      logic        charge_zero_q,
  output      logic        pwm_q,
  output      logic        full_q,
  output      logic        timeout_q,
  // Indication
  output      logic        buzzer_q,
  output      logic        bias_led_q,
  output      logic        led_out_q,
  output      logic        led_oe_q,
  output      logic [2:0]  prog_out_q,
  output      logic [2:0]  prog_oe_q
);

  localparam int CW = 32;
  localparam int PW = charge_timer_pkg::PEAK_W;
  localparam logic [CW-1:0] ONE = 32'h1;
  localparam logic [CW-1:0] VP_LIM = ONE << VPEAK_EXP;
  localparam logic [CW-1:0] SENSE_START = VP_LIM - (ONE << SENSE_EXP);
  localparam logic [8:0] DEN = 9'(charge_timer_pkg::PEAK_DEN);
  localparam logic [7:0] PWM_LAST = 8'(charge_timer_pkg::PWM_CYC - 1);
  localparam logic [7:0] DUTY_MAX = 8'(charge_timer_pkg::PWM_CYC *
      charge_timer_pkg::DUTY_PCT / charge_timer_pkg::PCT);
  localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYC - 1);
  localparam logic [15:0] BUZZ_LEN = 16'(charge_timer_pkg::BUZZ_CYC);

  logic [18:0] sync1_q, sync2_q;
  logic [3:0]  prev_q;
  charge_timer_pkg::state_e state_q;
  charge_timer_pkg::ctrl_s  ctrl_q;
  charge_timer_pkg::div_s   div_q;
  logic [CW-1:0] init_cnt_q, vp_cnt, tout_cnt;
  logic [CW-1:0] presc_lim, ntc_lim, tout_lim;
  logic [PW-1:0] peak_q, prev_ntc_q, drop;
  logic [22:0]   drop_x;
  logic [3:0]    pk_cnt_q, sl_cnt_q;
  logic [15:0]   buzz_cnt_q;
  logic [7:0]    pwm_cnt_q;
  logic          have_prev_q, holdoff_q;
  logic inhibit, hi_lvl, lsp, temp, insert, refr, stop;
  logic tick, run_t, fast, prot, init_done, ins_rise, refr_end, lsp_fall;
  logic hi_rise, sw_restart, hold_restart, tout_restart;
  logic vp_last, ntc_last, tout_last, hold_last, pk_qual, sl_qual;
  logic det_ok, full_evt, drive;
  logic aw_ok_q, w_ok_q, do_wr, wr_hit;
  logic [3:0]  awaddr_q, wstrb_q;
  logic [31:0] wdata_q, ctrl_word, rd_word;

  // Two flip-flops on every pin before any logic reads it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {presc_div_in, tout_div_in, slope_div_in,
                  standby_control_pin_low, standby_control_pin_high,
                  low_supply_in, temp_prot_in, battery_insert_in,
                  discharge_request_pin, pwm_stop_in};
      sync2_q <= sync1_q;
    end
  end

  assign {inhibit, hi_lvl, lsp, temp, insert, refr, stop} = sync2_q[6:0];
  assign fast = (state_q == charge_timer_pkg::st_fast);
  assign prot = lsp || temp;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prev_q <= '0;
    else
      prev_q <= {insert, refr, hi_lvl, lsp};
  end

  assign ins_rise   = insert && !prev_q[3];
  assign refr_end   = !refr && prev_q[2];
  assign hi_rise    = hi_lvl && !prev_q[1];
  assign lsp_fall   = !lsp && prev_q[0];
  assign init_done  = (state_q == charge_timer_pkg::st_init) &&
                      (init_cnt_q == INIT_LAST);
  assign sw_restart = do_wr && (awaddr_q == charge_timer_pkg::ADDR_CTRL) &&
                      wstrb_q[0] && wdata_q[2];
  assign tout_restart = init_done || ins_rise || sw_restart;
  assign hold_restart = tout_restart || refr_end || lsp_fall;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_cnt_q <= '0;
      div_q      <= '{default: charge_timer_pkg::DIV_MIN};
    end
    else if (state_q == charge_timer_pkg::st_init)
    begin
      init_cnt_q <= init_cnt_q + 1'b1;
      if (init_done)
        div_q <= '{presc: (sync2_q[18:15] == 4'h0) ?
                          charge_timer_pkg::DIV_MIN : sync2_q[18:15],
                   tout:  (sync2_q[14:11] == 4'h0) ?
                          charge_timer_pkg::DIV_MIN : sync2_q[14:11],
                   slope: (sync2_q[10:7] == 4'h0) ?
                          charge_timer_pkg::DIV_MIN : sync2_q[10:7]};
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= charge_timer_pkg::st_init;
    else
      case (state_q)
        charge_timer_pkg::st_init:
          if (init_done)
            state_q <= charge_timer_pkg::st_fast;
        charge_timer_pkg::st_fast:
          if (refr)
            state_q <= charge_timer_pkg::st_refresh;
          else if (full_evt)
            state_q <= charge_timer_pkg::st_full;
          else if (tout_last)
            state_q <= charge_timer_pkg::st_timeout;
        charge_timer_pkg::st_full, charge_timer_pkg::st_timeout:
          if (refr)
            state_q <= charge_timer_pkg::st_refresh;
          else if (tout_restart)
            state_q <= charge_timer_pkg::st_fast;
        charge_timer_pkg::st_refresh:
          if (!refr)
            state_q <= charge_timer_pkg::st_fast;
        default:
          state_q <= charge_timer_pkg::st_init;
      endcase
  end

  assign presc_lim = {28'h0, div_q.presc};
  assign ntc_lim   = (ONE << NTC_EXP) * {28'h0, div_q.slope};
  assign tout_lim  = {28'h0, div_q.tout} << TOUT_EXP;
  assign run_t     = tick && !inhibit;

  period_counter #(.W(CW)) u_presc (
    .clk(clk), .rstn(rstn), .en(1'b1), .clr(1'b0),
    .limit(presc_lim), .count_q(), .last(tick));

  period_counter #(.W(CW)) u_vpeak (
    .clk(clk), .rstn(rstn), .en(run_t && fast && ctrl_q.peak_en),
    .clr(!fast), .limit(VP_LIM), .count_q(vp_cnt), .last(vp_last));

  period_counter #(.W(CW)) u_ntc (
    .clk(clk), .rstn(rstn), .en(run_t && fast && ctrl_q.slope_en),
    .clr(!fast), .limit(ntc_lim), .count_q(), .last(ntc_last));

  period_counter #(.W(CW)) u_tout (
    .clk(clk), .rstn(rstn), .en(run_t && !prot && fast && !timeout_q),
    .clr(tout_restart), .limit(tout_lim), .count_q(tout_cnt),
    .last(tout_last));

  period_counter #(.W(CW)) u_hold (
    .clk(clk), .rstn(rstn), .en(run_t && holdoff_q), .clr(hold_restart),
    .limit(tout_lim >> charge_timer_pkg::HOLD_SHIFT), .count_q(),
    .last(hold_last));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      holdoff_q <= 1'b1;
    else if (hold_restart)
      holdoff_q <= 1'b1;
    else if (hold_last || (hi_rise && fast))
      holdoff_q <= 1'b0;
  end

  // quarter percent drop, scaled to avoid a divider
  assign drop    = peak_q - vbat_data;
  assign drop_x  = {9'h0, drop} * {14'h0, DEN};
  assign pk_qual = (vbat_data < peak_q) && (drop_x >= {9'h0, peak_q});
  // rise in temperature lowers the thermistor voltage
  assign sl_qual = have_prev_q && (ntc_data < prev_ntc_q) &&
                   ((prev_ntc_q - ntc_data) > ctrl_q.slope_thr);

  // store only the maximum; replace previous sample
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      peak_q      <= '0;
      prev_ntc_q  <= '0;
      have_prev_q <= 1'b0;
    end
    else if (tout_restart)
    begin
      peak_q      <= '0;
      have_prev_q <= 1'b0;
    end
    else
    begin
      if (vp_last && (vbat_data > peak_q))
        peak_q <= vbat_data;
      if (ntc_last)
      begin
        prev_ntc_q  <= ntc_data;
        have_prev_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pk_cnt_q <= '0;
      sl_cnt_q <= '0;
    end
    else
    begin
      if (vp_last)
        pk_cnt_q <= (pk_qual && pk_cnt_q != 4'hf) ? pk_cnt_q + 1'b1 : '0;
      if (ntc_last)
        sl_cnt_q <= (sl_qual && sl_cnt_q != 4'hf) ? sl_cnt_q + 1'b1 : '0;
    end
  end

  assign det_ok   = fast && !holdoff_q;
  assign full_evt = det_ok &&
      ((vp_last && pk_qual &&
        ({1'b0, pk_cnt_q} + 5'h1) >= {1'b0, ctrl_q.filt_n}) ||
       (ntc_last && sl_qual &&
        ({1'b0, sl_cnt_q} + 5'h1) >= {1'b0, ctrl_q.filt_n}));

  // termination flags, set wins over restart
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      full_q    <= 1'b0;
      timeout_q <= 1'b0;
    end
    else
    begin
      full_q    <= full_evt || (full_q && !tout_restart);
      timeout_q <= tout_last || (timeout_q && !tout_restart);
    end
  end

  // zero current over the sense window
  assign drive = fast && !inhibit && !prot;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      charge_on_q   <= 1'b0;
      charge_zero_q <= 1'b0;
    end
    else
    begin
      charge_on_q   <= drive;
      charge_zero_q <= fast && ctrl_q.peak_en && (vp_cnt >= SENSE_START);
    end
  end

  // set only at cycle start, so one pulse per cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwm_cnt_q <= '0;
      pwm_q     <= 1'b0;
    end
    else
    begin
      pwm_cnt_q <= (pwm_cnt_q == PWM_LAST) ? '0 : pwm_cnt_q + 1'b1;
      if (!drive || charge_zero_q || stop || pwm_cnt_q >= DUTY_MAX)
        pwm_q <= 1'b0;
      else if (pwm_cnt_q == 8'h0)
        pwm_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      buzz_cnt_q <= '0;
      buzzer_q   <= 1'b0;
    end
    else if (ins_rise || refr_end || full_evt)
    begin
      buzz_cnt_q <= BUZZ_LEN;
      buzzer_q   <= 1'b1;
    end
    else
    begin
      buzz_cnt_q <= (buzz_cnt_q != 16'h0) ? buzz_cnt_q - 1'b1 : '0;
      buzzer_q   <= (buzz_cnt_q > 16'h1);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bias_led_q <= 1'b0;
      led_out_q  <= 1'b0;
      led_oe_q   <= 1'b0;
      prog_out_q <= '0;
      prog_oe_q  <= '0;
    end
    else if (inhibit || state_q == charge_timer_pkg::st_init)
    begin
      bias_led_q <= 1'b0;
      led_out_q  <= 1'b0;
      led_oe_q   <= 1'b0;
      prog_out_q <= '0;
      prog_oe_q  <= '0;
    end
    else
    begin
      bias_led_q <= 1'b1;
      led_out_q  <= fast && !prot;
      led_oe_q   <= !prot;
      prog_out_q <= {state_q == charge_timer_pkg::st_refresh, fast, prot};
      prog_oe_q  <= '1;
    end
  end

  // AXI4-Lite: address and data taken in either order
  assign do_wr  = aw_ok_q && w_ok_q && !s_axi_bvalid;
  assign wr_hit = (awaddr_q[1:0] == 2'h0);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= charge_timer_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? charge_timer_pkg::RESP_OKAY :
                                charge_timer_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb
  begin
    ctrl_word = {11'h0, ctrl_q};
    for (int b = 0; b < 4; b++)
      if (wstrb_q[b])
        ctrl_word[8*b +: 8] = wdata_q[8*b +: 8];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= charge_timer_pkg::CTRL_RESET;
    else if (do_wr && awaddr_q == charge_timer_pkg::ADDR_CTRL)
      ctrl_q <= charge_timer_pkg::ctrl_s'({ctrl_word[20:3], 1'b0,
                                           ctrl_word[1:0]});
  end

  always_comb
  begin
    case (s_axi_araddr)
      charge_timer_pkg::ADDR_CTRL:   rd_word = {11'h0, ctrl_q};
      charge_timer_pkg::ADDR_STATUS: rd_word = {24'h0, holdoff_q, timeout_q,
                                         full_q, inhibit, 1'b0, state_q};
      charge_timer_pkg::ADDR_PEAK:   rd_word = {18'h0, peak_q};
      charge_timer_pkg::ADDR_TIMER:  rd_word = tout_cnt;
      default:                       rd_word = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= charge_timer_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0) ?
          charge_timer_pkg::RESP_OKAY : charge_timer_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rise_sample;
    vp_last && (vbat_data > peak_q) && !tout_restart;
  endsequence
  sequence s_low_sample;
    vp_last && (vbat_data <= peak_q) && !tout_restart;
  endsequence

  property p_peak_load;
    s_rise_sample |=> (peak_q == $past(vbat_data));
  endproperty
  a_peak_load: assert property (p_peak_load)
    else $error("peak did not load higher sample");

  property p_peak_keep;
    s_low_sample |=> $stable(peak_q);
  endproperty
  a_peak_keep: assert property (p_peak_keep)
    else $error("peak changed on lower sample");

  property p_inhibit;
    inhibit |=> (!pwm_q && !charge_on_q && !led_oe_q && prog_oe_q == 3'h0);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("outputs active during inhibit");

  property p_tout_hold;
    (prot || inhibit) && !tout_restart |=> $stable(tout_cnt);
  endproperty
  a_tout_hold: assert property (p_tout_hold)
    else $error("time-out count moved while held");

  property p_tout_flag;
    tout_last |=> timeout_q && (state_q != charge_timer_pkg::st_fast);
  endproperty
  a_tout_flag: assert property (p_tout_flag)
    else $error("time-out expiry not flagged");

  property p_bias_init;
    (state_q == charge_timer_pkg::st_init) |=> !bias_led_q;
  endproperty
  a_bias_init: assert property (p_bias_init)
    else $error("bias output on during start-up");

  property p_holdoff;
    holdoff_q && !full_q |=> !full_q;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("full decided during hold-off");

  // Only the cycle start may raise the output, so no second pulse
  property p_pwm_once;
    (pwm_cnt_q != 8'h0) |=> !$rose(pwm_q);
  endproperty
  a_pwm_once: assert property (p_pwm_once)
    else $error("pwm pulsed twice in a cycle");

  property p_duty;
    (pwm_cnt_q == DUTY_MAX) |=> !pwm_q;
  endproperty
  a_duty: assert property (p_duty)
    else $error("pwm duty over ceiling");

  property p_sense;
    vp_last |-> charge_zero_q;
  endproperty
  a_sense: assert property (p_sense)
    else $error("sample taken with current on");

  property p_led_fast;
    fast && !prot && !inhibit |=> led_out_q && led_oe_q;
  endproperty
  a_led_fast: assert property (p_led_fast)
    else $error("single LED not lit in fast charge");

  property p_buzz;
    (ins_rise || refr_end || full_evt) |=> buzzer_q;
  endproperty
  a_buzz: assert property (p_buzz)
    else $error("buzzer silent after event");

endmodule : charge_timer_full_detect

// ---- tb/charge_timer_full_detect_tb.sv ----
// Self-checking bench for the charge timer: register bus, peak detect,
// time-out freeze. Assumes shortened timing parameters and presc = 1.
`timescale 1ns/1ps
module charge_timer_full_detect_tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_s;
  note_s       q[$];
  note_s       e;
  int          errors = 0;
  int          n_compared = 0;
  int          seed = 46;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        standby_control_pin_low = 1'h0, standby_control_pin_high = 1'h0;
  logic        low_supply_in = 1'h0, temp_prot_in = 1'h0;
  logic        battery_insert_in = 1'h0, discharge_request_pin = 1'h0;
  logic        pwm_stop_in = 1'h0;
  logic [3:0]  presc_div_in = 4'h1, tout_div_in = 4'hf, slope_div_in = 4'h1;
  logic [13:0] vbat_data = 14'h03e8, ntc_data = 14'h2000;
  logic        charge_on_q, charge_zero_q, pwm_q, full_q, timeout_q;
  logic        buzzer_q, bias_led_q, led_out_q, led_oe_q;
  logic [2:0]  prog_out_q, prog_oe_q;

  charge_timer_full_detect #(.TOUT_EXP(8), .NTC_EXP(5), .VPEAK_EXP(6),
    .SENSE_EXP(2), .INIT_CYC(20)) u_dut (.*);

  always #5 clk = ~clk;
  always @(posedge clk)
    pwm_stop_in <= 1'($random(seed));

  task automatic end_sim;
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    q.push_back('{32'h0, 32'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w)
    begin
      @(posedge clk);
      if (aw && s_axi_awready)
      begin
        aw = 0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready)
      begin
        w = 0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1)
      @(posedge clk);
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    q.push_back('{d, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : rd

  // Each bus answer is matched against the oldest expectation
  always @(posedge clk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      e = q.pop_front();
      n_compared++;
      if ((s_axi_rvalid ? {s_axi_rresp, s_axi_rdata & e.m}
                        : {s_axi_bresp, 32'h0}) !== {e.r, e.d})
      begin
        errors++;
        $display("MISMATCH %0t bus answer differs", $time);
      end
    end

  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    rd(4'h0, 32'h201b, 32'h1fffff, 2'h0);
    rd(4'h4, 32'h0, 32'h7, 2'h0);
    rd(4'h1, 32'h0, 32'h0, 2'h2);
    wr(4'h8, 32'h1234, 2'h0);
    wr(4'h3, 32'h0, 2'h2);
    repeat (30) @(posedge clk);
    rd(4'h4, 32'h1, 32'h7, 2'h0);
    standby_control_pin_high <= 1'h1;
    vbat_data <= 14'h07d0;
    repeat (200) @(posedge clk);
    // Small drop stays below the full threshold and is never stored
    vbat_data <= 14'h07cc;
    repeat (200) @(posedge clk);
    rd(4'h8, 32'h7d0, 32'h3fff, 2'h0);
    rd(4'h4, 32'h0, 32'h20, 2'h0);
    vbat_data <= 14'h07ca;
    repeat (300) @(posedge clk);
    rd(4'h4, 32'h20, 32'h20, 2'h0);
    discharge_request_pin <= 1'h1;
    repeat (20) @(posedge clk);
    discharge_request_pin <= 1'h0;
    wr(4'h0, 32'h2018, 2'h0);
    // Protection or inhibit must stretch the time-out by its length
    for (int c = 0; c < 4; c++)
    begin
      battery_insert_in <= 1'h0;
      repeat (4) @(posedge clk);
      battery_insert_in <= 1'h1;
      repeat (1000) @(posedge clk);
      if (c > 0)
        {low_supply_in, temp_prot_in, standby_control_pin_low} <= 3'h4 >> (c-1);
      repeat (c > 0 ? 200 : 0) @(posedge clk);
      {low_supply_in, temp_prot_in, standby_control_pin_low} <= 3'h0;
      // Past the unheld expiry when c > 0, short of the held one (and of any expiry when c = 0)
      repeat (2700) @(posedge clk);
      rd(4'h4, 32'h0, 32'h40, 2'h0);
      repeat (160) @(posedge clk);
      rd(4'h4, 32'h40, 32'h40, 2'h0);
    end
    end_sim();
  end
endmodule : charge_timer_full_detect_tb
